// ===== mac_fc_pkg.sv
// Purpose: shared constants for the MAC flow-control side-band block
// Assumes: 32-bit AXI4-Lite register access, 64-bit datapath per clock
// Notes:   all offsets, field positions and timing counts live here

package mac_fc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          AXI_ADDR_W    = 4;           // byte address width
	localparam int          AXI_DATA_W    = 32;          // data width
	localparam logic [3:0]  ADDR_CTRL     = 4'h0;        // pause request control
	localparam logic [3:0]  ADDR_STATUS   = 4'h4;        // receive pause status
	localparam logic [1:0]  CTRL_RESET    = 2'h0;        // no request pending
	localparam int          CTRL_XON_BIT  = 0;           // xon request field
	localparam int          CTRL_XOFF_BIT = 1;           // xoff request field
	localparam logic [1:0]  RESP_OKAY     = 2'h0;        // normal answer
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;        // unmapped address

	// ----------------------------------------------------------------
	// pause timing
	// ----------------------------------------------------------------
	localparam int          QUANTA_W        = 16;        // width of one quanta field
	localparam int          QUANTA_BITS     = 512;       // bit periods per quanta unit
	localparam int          BITS_PER_CYCLE  = 64;        // datapath bits per clock
	localparam int          CYCLES_PER_QUANTA = QUANTA_BITS / BITS_PER_CYCLE;
	localparam int          SUB_W           = $clog2(CYCLES_PER_QUANTA);
	localparam logic [SUB_W-1:0] SUB_LAST   = SUB_W'(CYCLES_PER_QUANTA - 1);
	localparam logic [SUB_W-1:0] SUB_ZERO   = SUB_W'(0);
	localparam logic [QUANTA_W-1:0] QUANTA_ZERO = QUANTA_W'(0);
	localparam logic [QUANTA_W-1:0] QUANTA_ONE  = QUANTA_W'(1);

endpackage

// ===== pfc_pause_timer.sv
// Purpose: one receive priority pause timer, counting quanta in eight-cycle units
// Assumes: load and clear come from the same clock domain
// Notes:   pause output is registered and high while quanta remain

`timescale 1ns/1ps

module pfc_pause_timer
	import mac_fc_pkg::*;
(
	input  wire logic                i_clk,       // datapath clock
	input  wire logic                i_rst_n,     // async reset, active low
	input  wire logic                i_load,      // non-zero quanta received
	input  wire logic [QUANTA_W-1:0] i_load_val,  // quanta received
	input  wire logic                i_clear,     // zero quanta received
	output logic                     o_pause      // pause for this priority
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [QUANTA_W-1:0] quanta_q, quanta_d;  // quanta units left
	logic [SUB_W-1:0]    sub_q, sub_d;        // cycle within current unit
	logic                pause_q, pause_d;    // registered pause level

	// next-state: reload, clear, or count down
	always_comb
	begin
		quanta_d = quanta_q;
		sub_d    = sub_q;
		if (i_load)
		begin
			// fresh quanta restarts the whole timer [R10]
			quanta_d = i_load_val;
			sub_d    = SUB_ZERO;
		end
		else if (i_clear)
		begin
			// zero quanta ends the pause at once [R5]
			quanta_d = QUANTA_ZERO;
			sub_d    = SUB_ZERO;
		end
		else if (quanta_q != QUANTA_ZERO)
		begin
			// one unit lasts eight clocks [R4] [R9] [R10]
			if (sub_q == SUB_LAST)
			begin
				sub_d    = SUB_ZERO;
				quanta_d = quanta_q - QUANTA_ONE;
			end
			else
			begin
				sub_d = sub_q + SUB_W'(1);
			end
		end
		// expiry drops the pause without another frame [R6]
		pause_d = (quanta_d != QUANTA_ZERO);
	end

	// registers
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			quanta_q <= QUANTA_ZERO;
			sub_q    <= SUB_ZERO;
			pause_q  <= 1'b0;
		end
		else
		begin
			quanta_q <= quanta_d;
			sub_q    <= sub_d;
			pause_q  <= pause_d;
		end
	end

	assign o_pause = pause_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	timer_reload_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R10]
		i_load |=> (quanta_q == $past(i_load_val)) && (sub_q == SUB_ZERO))
		else $error("timer did not reload");

	// a zero-quanta frame may legally cut the unit short, so only clear-free spans are checked
	one_unit_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R4]
		(i_load && i_load_val == QUANTA_ONE) ##1 (!i_clear)[*7] |=> o_pause)
		else $error("one quanta unit not held for eight cycles");

	expiry_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R6]
		(i_load && i_load_val == QUANTA_ONE) ##1 (!i_load && !i_clear)[*8] |=> !o_pause)
		else $error("pause not dropped at timer expiry");

endmodule

// ===== mac_flow_ctrl.sv
// Purpose: flow-control side-band logic of a 10 Gb/s Ethernet MAC
// Assumes: user logic and parsed PFC frames share I_REF_CLK
// Notes:   AXI4-Lite slave holds the pause request control and pause status
//
// Contract
// [R1] pause request bit0 xon, bit1 xoff
// [R2] control register beats pause request input
// [R3] set pause bit on enabled non-zero quanta
// [R4] hold pause eight cycles per quanta unit
// [R5] enabled zero quanta clears pause bit immediately
// [R6] timer expiry clears pause bit
// [R7] pfc request bit 2k xon, 2k+1 xoff
// [R8] per-priority ports only with PFC enabled
// [R9] one quanta unit equals 512 bit times
// [R10] per-priority timer, reload, eight-cycle countdown

`timescale 1ns/1ps

module mac_flow_ctrl
	import mac_fc_pkg::*;
#(
	parameter int PRIO_N     = 8,  // enabled priority queues, 2..8
	parameter bit PFC_ENABLE = 1'b1 // priority-based flow control built in
)
(
	input  wire logic                       I_REF_CLK,                       // datapath clock
	input  wire logic                       I_NRST,                          // async reset, active low
	// axi4-lite slave
	input  wire logic [AXI_ADDR_W-1:0]      I_AWADDR,                        // write address
	input  wire logic                       I_AWVALID,                       // write address valid
	output logic                            O_AWREADY,                       // write address ready
	input  wire logic [AXI_DATA_W-1:0]      I_WDATA,                         // write data
	input  wire logic [3:0]                 I_WSTRB,                         // byte strobes
	input  wire logic                       I_WVALID,                        // write data valid
	output logic                            O_WREADY,                        // write data ready
	output logic [1:0]                      O_BRESP,                         // write response
	output logic                            O_BVALID,                        // write response valid
	input  wire logic                       I_BREADY,                        // write response ready
	input  wire logic [AXI_ADDR_W-1:0]      I_ARADDR,                        // read address
	input  wire logic                       I_ARVALID,                       // read address valid
	output logic                            O_ARREADY,                       // read address ready
	output logic [AXI_DATA_W-1:0]           O_RDATA,                         // read data
	output logic [1:0]                      O_RRESP,                         // read response
	output logic                            O_RVALID,                        // read data valid
	input  wire logic                       I_RREADY,                        // read data ready
	// user flow-control requests
	input  wire logic [1:0]                 I_PAUSE_FRAME_REQUEST_IN,        // bit0 xon, bit1 xoff
	input  wire logic [2*PRIO_N-1:0]        I_TX_PRIORITY_PAUSE_REQUEST_IN,  // per queue xon/xoff
	output logic [1:0]                      O_TX_PAUSE_GEN,                  // pause frame to send
	output logic [2*PRIO_N-1:0]             O_TX_PRIORITY_PAUSE_GEN,         // pfc request to send
	// parsed received PFC frame
	input  wire logic                       I_RX_PFC_VALID,                  // frame fields valid
	input  wire logic [PRIO_N-1:0]          I_RX_PFC_QUANTA_EN,              // quanta enable vector
	input  wire logic [QUANTA_W*PRIO_N-1:0] I_RX_PFC_QUANTA,                 // quanta field n at n*16
	output logic [PRIO_N-1:0]               O_RX_PRIORITY_PAUSE_OUT          // per priority pause
);

	// ----------------------------------------------------------------
	// axi write channel
	// ----------------------------------------------------------------
	logic                  aw_have_q, aw_have_d;  // address captured
	logic [AXI_ADDR_W-1:0] awaddr_q, awaddr_d;    // captured address
	logic                  w_have_q, w_have_d;    // data captured
	logic [1:0]            wdata_q, wdata_d;      // captured control bits
	logic                  wstrb0_q, wstrb0_d;    // low byte enabled
	logic                  bvalid_q, bvalid_d;    // response pending
	logic [1:0]            bresp_q, bresp_d;      // response code
	logic                  wr_ctrl;               // control register write

	// address and data taken in either order, answered once both held
	always_comb
	begin
		aw_have_d = aw_have_q;
		awaddr_d  = awaddr_q;
		w_have_d  = w_have_q;
		wdata_d   = wdata_q;
		wstrb0_d  = wstrb0_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		wr_ctrl   = 1'b0;
		if (I_AWVALID && O_AWREADY)
		begin
			aw_have_d = 1'b1;
			awaddr_d  = I_AWADDR;
		end
		if (I_WVALID && O_WREADY)
		begin
			w_have_d = 1'b1;
			wdata_d  = I_WDATA[1:0];
			wstrb0_d = I_WSTRB[0];
		end
		if (aw_have_q && w_have_q)
		begin
			// both halves present: commit and answer
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			if (awaddr_q[AXI_ADDR_W-1:2] == ADDR_CTRL[AXI_ADDR_W-1:2])
			begin
				wr_ctrl = wstrb0_q;
				bresp_d = RESP_OKAY;
			end
			else if (awaddr_q[AXI_ADDR_W-1:2] == ADDR_STATUS[AXI_ADDR_W-1:2])
			begin
				bresp_d = RESP_OKAY;  // read-only, write ignored
			end
			else
			begin
				bresp_d = RESP_SLVERR;
			end
		end
		if (bvalid_q && I_BREADY)
		begin
			bvalid_d = 1'b0;
		end
	end

	// write channel registers
	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			aw_have_q <= 1'b0;
			awaddr_q  <= ADDR_CTRL;
			w_have_q  <= 1'b0;
			wdata_q   <= CTRL_RESET;
			wstrb0_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			awaddr_q  <= awaddr_d;
			w_have_q  <= w_have_d;
			wdata_q   <= wdata_d;
			wstrb0_q  <= wstrb0_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	assign O_AWREADY = !aw_have_q && !bvalid_q;
	assign O_WREADY  = !w_have_q && !bvalid_q;
	assign O_BVALID  = bvalid_q;
	assign O_BRESP   = bresp_q;

	// ----------------------------------------------------------------
	// pause frame request arbitration
	// ----------------------------------------------------------------
	logic [1:0]            ctrl_q, ctrl_d;        // pending software request
	logic [1:0]            gen_q, gen_d;          // pause frame request out
	logic [2*PRIO_N-1:0]   pfc_gen_q, pfc_gen_d;  // pfc request out

	// software request is issued first, then clears itself
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (ctrl_q != CTRL_RESET)
		begin
			gen_d  = ctrl_q;                // register wins [R2]
			ctrl_d = CTRL_RESET;
		end
		else
		begin
			gen_d = I_PAUSE_FRAME_REQUEST_IN; // xon bit0, xoff bit1 [R1]
		end
		if (wr_ctrl)
		begin
			ctrl_d = wdata_q;               // new write wins over self-clear
		end
		// per queue xon at 2k, xoff at 2k+1 [R7] [R8]
		pfc_gen_d = PFC_ENABLE ? I_TX_PRIORITY_PAUSE_REQUEST_IN : '0;
	end

	// arbitration registers
	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			ctrl_q    <= CTRL_RESET;
			gen_q     <= CTRL_RESET;
			pfc_gen_q <= '0;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			gen_q     <= gen_d;
			pfc_gen_q <= pfc_gen_d;
		end
	end

	assign O_TX_PAUSE_GEN          = gen_q;
	assign O_TX_PRIORITY_PAUSE_GEN = pfc_gen_q;

	// ----------------------------------------------------------------
	// receive per-priority pause timers
	// ----------------------------------------------------------------
	logic [PRIO_N-1:0] rx_pause;  // timer outputs

	generate
		if (PFC_ENABLE)
		begin : g_pfc
			for (genvar n = 0; n < PRIO_N; n++)
			begin : g_prio
				logic [QUANTA_W-1:0] field;  // quanta field n
				assign field = I_RX_PFC_QUANTA[n*QUANTA_W +: QUANTA_W];
				// enabled non-zero field loads, enabled zero clears [R3] [R5]
				pfc_pause_timer u_timer (
					.i_clk      (I_REF_CLK),
					.i_rst_n    (I_NRST),
					.i_load     (I_RX_PFC_VALID && I_RX_PFC_QUANTA_EN[n] && (field != QUANTA_ZERO)),
					.i_load_val (field),
					.i_clear    (I_RX_PFC_VALID && I_RX_PFC_QUANTA_EN[n] && (field == QUANTA_ZERO)),
					.o_pause    (rx_pause[n])
				);
			end
		end
		else
		begin : g_nopfc
			assign rx_pause = '0;  // feature absent, output held low [R8]
		end
	endgenerate

	assign O_RX_PRIORITY_PAUSE_OUT = rx_pause;

	// ----------------------------------------------------------------
	// axi read channel
	// ----------------------------------------------------------------
	logic                  rvalid_q, rvalid_d;  // read data pending
	logic [AXI_DATA_W-1:0] rdata_q, rdata_d;    // read data
	logic [1:0]            rresp_q, rresp_d;    // read response

	// one read at a time, answered the cycle after the address
	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (I_ARVALID && O_ARREADY)
		begin
			rvalid_d = 1'b1;
			rdata_d  = '0;
			rresp_d  = RESP_OKAY;
			if (I_ARADDR[AXI_ADDR_W-1:2] == ADDR_CTRL[AXI_ADDR_W-1:2])
			begin
				rdata_d[1:0] = ctrl_q;
			end
			else if (I_ARADDR[AXI_ADDR_W-1:2] == ADDR_STATUS[AXI_ADDR_W-1:2])
			begin
				rdata_d[PRIO_N-1:0] = rx_pause;
			end
			else
			begin
				rresp_d = RESP_SLVERR;
			end
		end
		else if (rvalid_q && I_RREADY)
		begin
			rvalid_d = 1'b0;
		end
	end

	// read channel registers
	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end
		else
		begin
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

	assign O_ARREADY = !rvalid_q;
	assign O_RVALID  = rvalid_q;
	assign O_RDATA   = rdata_q;
	assign O_RRESP   = rresp_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	reg_priority_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST) // [R2]
		(ctrl_q != CTRL_RESET) |=> (O_TX_PAUSE_GEN == $past(ctrl_q)))
		else $error("register request lost to input");

	input_pass_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST) // [R1]
		(ctrl_q == CTRL_RESET) |=> (O_TX_PAUSE_GEN == $past(I_PAUSE_FRAME_REQUEST_IN)))
		else $error("pause request input not forwarded");

	pfc_pass_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST) // [R7]
		PFC_ENABLE |=> (O_TX_PRIORITY_PAUSE_GEN == $past(I_TX_PRIORITY_PAUSE_REQUEST_IN)))
		else $error("pfc request not forwarded");

	pfc_absent_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST) // [R8]
		!PFC_ENABLE |-> (O_RX_PRIORITY_PAUSE_OUT == '0) && (O_TX_PRIORITY_PAUSE_GEN == '0))
		else $error("pfc outputs active without pfc");

	rx_pause_set_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST) // [R3]
		(PFC_ENABLE && I_RX_PFC_VALID && I_RX_PFC_QUANTA_EN[0] && (I_RX_PFC_QUANTA[QUANTA_W-1:0] != QUANTA_ZERO))
		|=> O_RX_PRIORITY_PAUSE_OUT[0])
		else $error("pause bit not set on non-zero quanta");

	rx_pause_clr_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST) // [R5]
		(I_RX_PFC_VALID && I_RX_PFC_QUANTA_EN[0] && (I_RX_PFC_QUANTA[QUANTA_W-1:0] == QUANTA_ZERO))
		|=> !O_RX_PRIORITY_PAUSE_OUT[0])
		else $error("pause bit not cleared on zero quanta");

	write_answer_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(aw_have_q && w_have_q) |=> O_BVALID)
		else $error("write not answered after both halves");

endmodule

// ===== flow_user_model.sv
// Purpose: user-logic model feeding pause requests and parsed PFC frames
// Assumes: runs on the datapath clock and changes just after rising edges
// Notes:   the testbench calls its tasks through the instance

`timescale 1ns/1ps

module flow_user_model
	import mac_fc_pkg::*;
#(
	parameter int PRIO_N = 2 // priority queues modelled
)
(
	input  wire logic                  i_clk,         // datapath clock
	output logic [1:0]                 o_pause_req,   // bit0 xon, bit1 xoff
	output logic [2*PRIO_N-1:0]        o_prio_req,    // queue k: bit 2k xon, 2k+1 xoff
	output logic                       o_frame_valid, // one-cycle frame strobe
	output logic [PRIO_N-1:0]          o_quanta_en,   // quanta enable vector
	output logic [QUANTA_W*PRIO_N-1:0] o_quanta       // quanta fields
);
	// ----------------------------------------------------------------
	// idle values at time zero
	// ----------------------------------------------------------------
	initial
	begin
		o_pause_req   = 2'h0;
		o_prio_req    = '0;
		o_frame_valid = 1'b0;
		o_quanta_en   = '0;
		o_quanta      = '0;
	end

	// level requests, held until changed by the next call
	task automatic set_req(input logic [1:0] p, input logic [2*PRIO_N-1:0] q);
		@(posedge i_clk);
		o_pause_req <= p;
		o_prio_req  <= q;
	endtask

	// one parsed frame; fields show the inverse once the strobe drops
	task automatic send_frame(input logic [PRIO_N-1:0] en, input logic [QUANTA_W*PRIO_N-1:0] q);
		@(posedge i_clk);
		o_frame_valid <= 1'b1;
		o_quanta_en   <= en;
		o_quanta      <= q;
		@(posedge i_clk);
		o_frame_valid <= 1'b0;
		o_quanta_en   <= ~en;
		o_quanta      <= ~q;
	endtask
endmodule

// ===== tb.sv
// Purpose: self-checking bench for the MAC flow-control side-band block
// Assumes: two priority queues, one build with flow control and one without
// Notes:   axi4-lite master tasks plus pause timing checks

`timescale 1ns/1ps

module tb;
	import mac_fc_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int PN = 2;                   // priority queues under test
	logic                  clk;              // datapath clock
	logic                  nrst;             // reset, active low
	logic [3:0]            awaddr;           // write address
	logic [3:0]            araddr;           // read address
	logic                  awvalid, wvalid;  // write request valids
	logic                  bready, arvalid;  // response ready, read valid
	logic                  rready;           // read data ready
	logic [31:0]           wdata;            // write data
	logic                  awready, wready;  // write readies
	logic                  bvalid, arready;  // write answer, read ready
	logic                  rvalid;           // read answer
	logic [1:0]            bresp, rresp;     // response codes
	logic [31:0]           rdata;            // read data
	logic [1:0]            pause_req;        // pause frame request
	logic [2*PN-1:0]       prio_req;         // pfc request
	logic [1:0]            pause_gen;        // pause frame to send
	logic [2*PN-1:0]       prio_gen;         // pfc request to send
	logic                  fr_valid;         // frame strobe
	logic [PN-1:0]         fr_en;            // quanta enables
	logic [QUANTA_W*PN-1:0] fr_q;            // quanta fields
	logic [PN-1:0]         pause_out;        // per priority pause
	logic [1:0]            resp;             // response seen
	logic [31:0]           data;             // read data seen
	int                    error_cnt;        // mismatches
	int                    samples_checked;  // comparisons

	// ----------------------------------------------------------------
	// design and user-logic model
	// ----------------------------------------------------------------
	mac_flow_ctrl #(.PRIO_N(PN), .PFC_ENABLE(1'b1)) i_dut (
		.I_REF_CLK(clk), .I_NRST(nrst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
		.I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
		.O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
		.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.I_PAUSE_FRAME_REQUEST_IN(pause_req), .I_TX_PRIORITY_PAUSE_REQUEST_IN(prio_req),
		.O_TX_PAUSE_GEN(pause_gen), .O_TX_PRIORITY_PAUSE_GEN(prio_gen), .I_RX_PFC_VALID(fr_valid),
		.I_RX_PFC_QUANTA_EN(fr_en), .I_RX_PFC_QUANTA(fr_q), .O_RX_PRIORITY_PAUSE_OUT(pause_out));

	flow_user_model #(.PRIO_N(PN)) i_user (
		.i_clk(clk), .o_pause_req(pause_req), .o_prio_req(prio_req),
		.o_frame_valid(fr_valid), .o_quanta_en(fr_en), .o_quanta(fr_q));

	// second build without flow control: its per-priority outputs must stay low
	logic [PN-1:0]         np_pause;         // pause out, pfc absent
	logic [2*PN-1:0]       np_gen;           // pfc request out, pfc absent
	mac_flow_ctrl #(.PRIO_N(PN), .PFC_ENABLE(1'b0)) i_dut_nopfc (
		.I_REF_CLK(clk), .I_NRST(nrst), .I_AWADDR(awaddr), .I_AWVALID(1'b0), .O_AWREADY(),
		.I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(1'b0), .O_WREADY(), .O_BRESP(), .O_BVALID(),
		.I_BREADY(1'b1), .I_ARADDR(araddr), .I_ARVALID(1'b0), .O_ARREADY(), .O_RDATA(), .O_RRESP(),
		.O_RVALID(), .I_RREADY(1'b1), .I_PAUSE_FRAME_REQUEST_IN(pause_req),
		.I_TX_PRIORITY_PAUSE_REQUEST_IN(prio_req), .O_TX_PAUSE_GEN(), .O_TX_PRIORITY_PAUSE_GEN(np_gen),
		.I_RX_PFC_VALID(fr_valid), .I_RX_PFC_QUANTA_EN(fr_en), .I_RX_PFC_QUANTA(fr_q),
		.O_RX_PRIORITY_PAUSE_OUT(np_pause));

	// 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	// compare and count
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// write: address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_hs, w_hs, b_hs;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever
		begin
			@(negedge clk);
			aw_hs = awvalid & awready;
			w_hs  = wvalid & wready;
			b_hs  = bvalid & bready;
			r     = bresp;
			@(posedge clk);
			if (aw_hs)
				awvalid <= 1'b0;
			if (w_hs)
				wvalid <= 1'b0;
			if (b_hs)
			begin
				bready <= 1'b0;
				break;
			end
		end
	endtask

	// read: data and response sampled at the falling edge that sees rvalid
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_hs, r_hs;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever
		begin
			@(negedge clk);
			ar_hs = arvalid & arready;
			r_hs  = rvalid & rready;
			d     = rdata;
			r     = rresp;
			@(posedge clk);
			if (ar_hs)
				arvalid <= 1'b0;
			if (r_hs)
			begin
				rready <= 1'b0;
				break;
			end
		end
	endtask

	// pause bit high for cyc cycles after the capture edge, then low
	task automatic hold_chk(input int idx, input int cyc);
		repeat (cyc)
		begin
			#1;
			chk("pause held", 32'(pause_out[idx]), 32'h1);
			@(posedge clk);
		end
		#1;
		chk("pause expired", 32'(pause_out[idx]), 32'h0);
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		error_cnt = 0;
		samples_checked = 0;
		nrst = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk("reset ready", {29'h0, awready, wready, arready}, 32'h7);
		chk("reset pause", 32'(pause_out), 32'h0);
		// both request codes, every pfc bit set once
		for (int i = 1; i < 3; i++)
		begin
			i_user.set_req(2'(i), {2'(i), 2'(3 - i)});
			@(posedge clk);
			#1;
			chk("pause gen", 32'(pause_gen), 32'(i));
			chk("pfc gen", 32'(prio_gen), 32'({2'(i), 2'(3 - i)}));
			chk("pfc absent gen", 32'(np_gen), 32'h0);
		end
		// register request beats the xon input for one cycle
		i_user.set_req(2'h1, 4'h0);
		axi_wr(ADDR_CTRL, 32'h2, resp);
		chk("ctrl bresp", 32'(resp), 32'(RESP_OKAY));
		#1;
		chk("ctrl wins", 32'(pause_gen), 32'h2);
		@(posedge clk);
		#1;
		chk("input back", 32'(pause_gen), 32'h1);
		axi_rd(ADDR_CTRL, data, resp);
		chk("ctrl cleared", data, 32'h0);
		// unmapped and read-only places
		axi_wr(4'h8, 32'h3, resp);
		chk("unmapped bresp", 32'(resp), 32'(RESP_SLVERR));
		axi_wr(ADDR_STATUS, 32'h3, resp);
		chk("status bresp", 32'(resp), 32'(RESP_OKAY));
		axi_rd(4'hC, data, resp);
		chk("unmapped rresp", 32'(resp), 32'(RESP_SLVERR));
		chk("unmapped rdata", data, 32'h0);
		// two quanta on priority 0: sixteen cycles
		i_user.send_frame(2'b01, {16'h0000, 16'h0002});
		hold_chk(0, 16);
		// priority 0 field not enabled, priority 1 paused
		i_user.send_frame(2'b10, {16'h0003, 16'h0007});
		#1;
		chk("disabled field", 32'(pause_out[0]), 32'h0);
		chk("pfc absent pause", 32'(np_pause), 32'h0);
		axi_rd(ADDR_STATUS, data, resp);
		chk("status", data, 32'h2);
		repeat (30) @(posedge clk);
		#1;
		chk("prio1 expired", 32'(pause_out), 32'h0);
		// reload mid-count restarts the full time
		i_user.send_frame(2'b01, {16'h0000, 16'h0001});
		repeat (4) @(posedge clk);
		i_user.send_frame(2'b01, {16'h0000, 16'h0001});
		hold_chk(0, 8);
		// zero quanta clears at once
		i_user.send_frame(2'b01, {16'h0000, 16'h0005});
		repeat (3) @(posedge clk);
		i_user.send_frame(2'b01, {16'h0000, 16'h0000});
		#1;
		chk("zero clears", 32'(pause_out[0]), 32'h0);
		// let the clear check see the cycle after the frame
		repeat (2) @(posedge clk);
		#1;
		chk("zero stays", 32'(pause_out[0]), 32'h0);
		conclude();
	end

	// hang guard
	initial
	begin
		#(40 * 4000);
		error_cnt++;
		conclude();
	end
endmodule
